// file: dv/lms_chk.sv
// Concurrent checks on the scan link wires and the driver's scan outputs.
`timescale 1ns/1ns
module lms_chk (
  input  wire logic       I_SYS_CLK,
  input  wire logic       I_SYS_RST,
  input  wire logic       sclk,
  input  wire logic       serial_data_in,
  input  wire logic       serial_data_out,
  input  wire logic [4:0] O_LINE_SEL,
  input  wire logic       O_LINE_ON,
  input  wire logic       O_PWM,
  input  wire logic       O_GRAYSCALE_CLOCK_TICK
);
  default clocking cb @(posedge I_SYS_CLK); endclocking
  default disable iff (I_SYS_RST);

  a_sclk_high_two: assert property (
    $rose(sclk) |=> sclk ##1 !sclk)
    else $error("serial clock high phase is not two cycles");
  a_sclk_low_two: assert property (
    $fell(sclk) |=> !sclk ##1 sclk)
    else $error("serial clock low phase is not two cycles");
  a_sin_moves_low: assert property (
    $changed(serial_data_in) |-> !sclk)
    else $error("serial data in moved while serial clock high");
  a_serial_data_out_holds_high: assert property (
    sclk && $past(sclk) |-> $stable(serial_data_out))
    else $error("serial data out moved inside the high phase");
  a_line_sel_hold: assert property (
    O_LINE_ON && $past(O_LINE_ON) |-> $stable(O_LINE_SEL))
    else $error("scan line changed inside a segment");
  a_pwm_in_seg: assert property (
    O_PWM |-> O_LINE_ON)
    else $error("channel on outside a segment");
  a_seg_min_len: assert property (
    $rose(O_LINE_ON) |=> O_LINE_ON [*8])
    else $error("segment shorter than configured");
  a_switch_gap: assert property (
    $fell(O_LINE_ON) |=> !O_LINE_ON [*8])
    else $error("line switch shorter than configured");
  // The bench only uses multipliers of one or less, so ticks never touch.
  a_tick_pulse: assert property (
    O_GRAYSCALE_CLOCK_TICK |=> !O_GRAYSCALE_CLOCK_TICK)
    else $error("grayscale tick longer than one cycle");

  c_segment: cover property ($rose(O_LINE_ON));
  c_pwm: cover property ($rose(O_PWM));
  c_read_out: cover property ($changed(serial_data_out));
endmodule

// file: dv/tb.sv
// Self-checking bench joining the controller end and the driver end.
`timescale 1ns/1ns
module tb;
  logic        I_SYS_CLK;
  logic        I_SYS_RST;
  logic        start;
  logic        vsync;
  logic        gs_valid;
  logic        gs_used;
  logic        rd_valid;
  logic [3:0]  gs_line;
  logic [3:0]  rd_idx;
  logic [15:0] gs_value;
  logic [7:0]  addr_val;
  logic [47:0] cfg0_val;
  logic [47:0] cfg2_val;
  logic [47:0] cfg3_val;
  logic [47:0] open_val;
  logic [47:0] short_val;
  logic        ready;
  logic        rd_done;
  logic [47:0] rd_data;
  logic [4:0]  line_sel;
  logic        line_on;
  logic        pwm;
  logic        tick;
  logic        share_lsw;
  logic [19:0] blank_gclks;
  logic [7:0]  chip_addr;
  logic [47:0] cfg1_exp;
  logic [3:0]  idx_tab [7];
  logic [47:0] exp_tab [7];
  int          off_tab [4];
  int          n_fail;
  int          samples_checked;
  int          cyc;
  int          on_c;
  int          off_c;
  int          pwm_c;
  int          tk;
  int          k;
  logic [4:0]  sel;

  lms_link_if lms_link_if_i ();

  lms_ctl lms_ctl_i (
    .I_SYS_CLK      (I_SYS_CLK),
    .I_SYS_RST      (I_SYS_RST),
    .link           (lms_link_if_i),
    .I_START        (start),
    .I_CHIP_ADDR    (addr_val),
    .I_CFG0         (cfg0_val),
    .I_CFG2         (cfg2_val),
    .I_CFG3         (cfg3_val),
    .I_SEG_BASE     (10'h00A),
    .I_LSW_CODE     (4'h1),
    .I_BLANK_GCLKS  (blank_gclks),
    .I_SHARE_TO_LSW (share_lsw),
    .I_VSYNC        (vsync),
    .I_GS_VALID     (gs_valid),
    .I_GS_LINE      (gs_line),
    .I_GS_VALUE     (gs_value),
    .I_GS_USED      (gs_used),
    .I_RD_VALID     (rd_valid),
    .I_RD_IDX       (rd_idx),
    .O_READY        (ready),
    .O_RD_DATA      (rd_data),
    .O_RD_DONE      (rd_done)
  );

  lms_dev lms_dev_i (
    .I_SYS_CLK   (I_SYS_CLK),
    .I_SYS_RST   (I_SYS_RST),
    .link        (lms_link_if_i),
    .I_LED_OPEN  (open_val),
    .I_LED_SHORT (short_val),
    .O_LINE_SEL  (line_sel),
    .O_LINE_ON   (line_on),
    .O_PWM       (pwm),
    .O_GRAYSCALE_CLOCK_TICK (tick),
    .O_CHIP_ADDR (chip_addr)
  );

  lms_chk lms_chk_i (
    .I_SYS_CLK   (I_SYS_CLK),
    .I_SYS_RST   (I_SYS_RST),
    .sclk        (lms_link_if_i.sclk),
    .serial_data_in         (lms_link_if_i.serial_data_in),
    .serial_data_out        (lms_link_if_i.serial_data_out),
    .O_LINE_SEL  (line_sel),
    .O_LINE_ON   (line_on),
    .O_PWM       (pwm),
    .O_GRAYSCALE_CLOCK_TICK (tick)
  );

  initial begin
    I_SYS_CLK = 1'b0;
    forever #5 I_SYS_CLK = ~I_SYS_CLK;
  end

  task automatic print_verdict();
    if (n_fail == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic check(input logic [47:0] seen, input logic [47:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wait_ready();
    int w;
    w = 0;
    @(negedge I_SYS_CLK);
    while (ready !== 1'b1 && w < 3000) begin
      @(negedge I_SYS_CLK);
      w++;
    end
    if (w >= 3000) begin
      n_fail++;
      print_verdict();
    end
  endtask

  // Kind 1 is a frame sync, 2 a grayscale write, 3 a read.
  task automatic req(input int kind, input logic [3:0] a,
                     input logic [15:0] v, input logic u);
    wait_ready();
    @(posedge I_SYS_CLK);
    gs_line  <= a;
    rd_idx   <= a;
    gs_value <= v;
    gs_used  <= u;
    vsync    <= (kind == 1);
    gs_valid <= (kind == 2);
    rd_valid <= (kind == 3);
    @(posedge I_SYS_CLK);
    {vsync, gs_valid, rd_valid} <= 3'h0;
  endtask

  task automatic rd(input logic [3:0] idx, input logic [47:0] exp);
    int w;
    req(3, idx, 16'h0000, 1'b0);
    w = 0;
    while (rd_done !== 1'b1 && w < 1000) begin
      @(negedge I_SYS_CLK);
      w++;
    end
    if (w >= 1000) begin
      n_fail++;
      print_verdict();
    end
    check(rd_data, exp);
  endtask

  always @(posedge I_SYS_CLK) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      print_verdict();
    end
  end

  initial begin
    {start, vsync, gs_valid, rd_valid, gs_used} = 5'h00;
    gs_line   = 4'h0;
    rd_idx    = 4'h0;
    gs_value  = 16'h0000;
    addr_val  = 8'h05;
    share_lsw = 1'b0;
    blank_gclks = 20'h00067;
    // Multiplier one, two scan lines, two sub-periods.
    cfg0_val  = 48'h0000_0000_0211;
    cfg2_val  = 48'h0800_000F_0666;
    cfg3_val  = 48'h003B_54A9_FF00;
    open_val  = 48'hA5A5_0000_1234;
    short_val = 48'h0F0F_8000_0001;
    // Blank 103 over 4 segments: share 25, rest 3 gives one per sub-period.
    cfg1_exp  = {1'b0, 6'h01, 4'h1, 27'h0, 10'h023};
    idx_tab   = '{4'h0, 4'h1, 4'h2, 4'h3, 4'hE, 4'hF, 4'h7};
    exp_tab   = '{cfg0_val, cfg1_exp, cfg2_val, cfg3_val, open_val,
                  short_val, 48'h0};
    // Switch of 40 ticks, plus two blank ticks at each sub-period end.
    off_tab   = '{80, 84, 80, 300};
    n_fail = 0;
    samples_checked = 0;
    cyc = 0;
    I_SYS_RST = 1'b1;
    repeat (5) @(posedge I_SYS_CLK);
    I_SYS_RST <= 1'b0;
    @(posedge I_SYS_CLK) start <= 1'b1;
    @(posedge I_SYS_CLK) start <= 1'b0;
    wait_ready();
    check(48'(chip_addr), 48'(addr_val));
    for (int i = 0; i < 7; i++) begin
      rd(idx_tab[i], exp_tab[i]);
    end
    req(2, 4'h0, 16'hFFFF, 1'b1);
    req(2, 4'h1, 16'hFFFF, 1'b0);
    check(48'({line_on, pwm}), 48'h0);
    req(1, 4'h0, 16'h0000, 1'b0);
    k = 0;
    while (line_on !== 1'b1 && k < 2000) begin
      @(negedge I_SYS_CLK);
      k++;
    end
    if (k >= 2000) begin
      n_fail++;
      print_verdict();
    end
    for (int s = 0; s < 4; s++) begin
      on_c  = 0;
      off_c = 0;
      pwm_c = 0;
      tk    = 0;
      sel   = line_sel;
      while (line_on === 1'b1 && on_c < 300) begin
        on_c++;
        pwm_c += (pwm === 1'b1);
        tk += (tick === 1'b1);
        @(negedge I_SYS_CLK);
      end
      while (line_on !== 1'b1 && off_c < 300) begin
        off_c++;
        @(negedge I_SYS_CLK);
      end
      check(48'(on_c), 48'd70);
      check(48'(tk), 48'd35);
      check(48'(off_c), 48'(off_tab[s]));
      check(48'(sel), 48'(s % 2));
      check(48'(pwm_c != 0), 48'(s % 2 == 0));
    end
    // Mid-run reset, then a second bring-up with the share on the switch.
    // Blank 359 over 4 segments: share 89 adds two switch steps of 40.
    @(posedge I_SYS_CLK) I_SYS_RST <= 1'b1;
    share_lsw   <= 1'b1;
    blank_gclks <= 20'h00167;
    repeat (5) @(posedge I_SYS_CLK);
    I_SYS_RST <= 1'b0;
    @(posedge I_SYS_CLK) start <= 1'b1;
    @(posedge I_SYS_CLK) start <= 1'b0;
    check(48'({line_on, pwm}), 48'h0);
    wait_ready();
    check(48'(chip_addr), 48'(addr_val));
    rd(4'h1, {1'b0, 6'h01, 4'h3, 27'h0, 10'h00A});
    print_verdict();
  end
endmodule

// file: hw/lms_ctl.sv
// Display controller end: bring-up order, blank sharing and frame commands.
`timescale 1ns/1ns
`include "lms_map.svh"
module lms_ctl
  import lms_pkg::*;
(
  input  wire logic        I_SYS_CLK,
  input  wire logic        I_SYS_RST,
  lms_link_if.ctl          link,
  input  wire logic        I_START,
  input  wire logic [7:0]  I_CHIP_ADDR,
  input  wire logic [47:0] I_CFG0,
  input  wire logic [47:0] I_CFG2,
  input  wire logic [47:0] I_CFG3,
  input  wire logic [9:0]  I_SEG_BASE,
  input  wire logic [3:0]  I_LSW_CODE,
  input  wire logic [19:0] I_BLANK_GCLKS,
  input  wire logic        I_SHARE_TO_LSW,
  input  wire logic        I_VSYNC,
  input  wire logic        I_GS_VALID,
  input  wire logic [3:0]  I_GS_LINE,
  input  wire logic [15:0] I_GS_VALUE,
  input  wire logic        I_GS_USED,
  input  wire logic        I_RD_VALID,
  input  wire logic [3:0]  I_RD_IDX,
  output logic             O_READY,
  output logic [47:0]      O_RD_DATA,
  output logic             O_RD_DONE
);
  lms_ctl_type q;
  lms_ctl_type next_q;
  logic [19:0] n_sub;
  logic [19:0] n_line;
  logic [19:0] prod;
  logic [19:0] share;
  logic [19:0] left;
  logic [19:0] adj;
  logic [19:0] seg;
  logic [19:0] lsw;
  logic [47:0] cfg1;
  logic [63:0] word;
  logic        issue;
  logic        fall;
  logic        rise;

  // The segment share and sub-period share of blank clocks.
  always_comb begin
    n_sub  = {14'h0000, I_CFG0[`LMS_NSUB_HI:`LMS_NSUB_LO]} + 20'h00001;
    n_line = {15'h0000, I_CFG0[`LMS_NLINE_HI:`LMS_NLINE_LO]} + 20'h00001;
    prod   = 20'(n_sub * n_line);
    share  = (I_BLANK_GCLKS > prod) ? lms_div(I_BLANK_GCLKS, prod)
                                    : 20'h00000; // RQ5
    left   = 20'(I_BLANK_GCLKS - 20'(share * prod));
    adj    = (left > n_sub) ? lms_div(left, n_sub) : 20'h00000; // RQ7
    seg    = {10'h000, I_SEG_BASE};
    lsw    = {16'h0000, I_LSW_CODE};
    if (I_SHARE_TO_LSW) begin
      lsw = lsw + lms_div(share, {10'h000, `LMS_LSW_STEP}); // RQ6
    end else begin
      seg = seg + share; // RQ6
    end
    cfg1 = `LMS_CFG_RESET;
    cfg1[`LMS_SEG_HI:`LMS_SEG_LO] = seg[9:0];
    cfg1[`LMS_LSW_HI:`LMS_LSW_LO] = lsw[3:0];
    cfg1[`LMS_ADJ_HI:`LMS_ADJ_LO] = adj[5:0];
  end

  always_comb begin
    next_q = q;
    next_q.rd_done = 1'b0;
    word = 64'h0000_0000_0000_0000;
    issue = 1'b0;
    // The serial clock runs free from reset on, frames or not.
    next_q.div = ~q.div; // RQ22
    fall = q.div & q.sclk;
    rise = q.div & ~q.sclk;
    if (q.div) begin
      next_q.sclk = ~q.sclk; // RQ22
    end
    if (fall) begin
      if (q.tx_cnt != 7'd0) begin
        next_q.serial_data_in = q.tx[64]; // RQ23
        next_q.tx = {q.tx[63:0], 1'b0};
        next_q.tx_cnt = q.tx_cnt - 7'd1;
      end else begin
        next_q.serial_data_in = 1'b0;
      end
    end
    case (q.st)
      CS_IDLE: begin
        if (I_START) begin
          next_q.st = CS_BOOT;
          next_q.step = 3'd0;
        end
      end
      CS_BOOT: begin
        if (q.tx_cnt == 7'd0) begin
          issue = 1'b1;
          next_q.step = q.step + 3'd1;
          case (q.step)
            3'd0: word = {`LMS_CMD_CHAIN, 4'h0, `LMS_BROADCAST,
                          40'h00_0000_0000, I_CHIP_ADDR}; // RQ11
            3'd1: word = {`LMS_CMD_CFG_WR, `LMS_IDX_CFG0,
                          `LMS_BROADCAST, I_CFG0}; // RQ17
            3'd2: word = {`LMS_CMD_CFG_WR, `LMS_IDX_CFG1,
                          `LMS_BROADCAST, cfg1}; // RQ19
            3'd3: word = {`LMS_CMD_CFG_WR, `LMS_IDX_CFG2,
                          `LMS_BROADCAST, I_CFG2}; // RQ19
            3'd4: begin
              word = {`LMS_CMD_CFG_WR, `LMS_IDX_CFG3,
                      `LMS_BROADCAST, I_CFG3}; // RQ19
              next_q.st = CS_RUN;
            end
            default: issue = 1'b0;
          endcase
        end
      end
      CS_RUN: begin
        if (q.tx_cnt == 7'd0) begin
          if (I_VSYNC) begin
            issue = 1'b1;
            word = {`LMS_CMD_VSYNC, 4'h0, `LMS_BROADCAST,
                    48'h0000_0000_0000}; // RQ11
          end else if (I_GS_VALID) begin
            issue = 1'b1;
            word = {`LMS_CMD_GS_WR, 4'h0, I_CHIP_ADDR, 28'h000_0000,
                    I_GS_LINE,
                    I_GS_USED ? I_GS_VALUE : 16'h0000}; // RQ18 RQ20
          end else if (I_RD_VALID) begin
            issue = 1'b1;
            word = {`LMS_CMD_READ, I_RD_IDX, I_CHIP_ADDR,
                    48'h0000_0000_0000};
            next_q.st = CS_RDWAIT;
          end
        end
      end
      CS_RDWAIT: begin
        if (rise && q.tx_cnt == 7'd0 && link.serial_data_out) begin
          next_q.st = CS_RDGET;
          next_q.rd_cnt = `LMS_RD_BITS;
        end
      end
      CS_RDGET: begin
        if (rise) begin
          next_q.rd_sh = {q.rd_sh[46:0], link.serial_data_out}; // RQ23
          next_q.rd_cnt = q.rd_cnt - 6'd1;
          if (q.rd_cnt == 6'd1) begin
            next_q.rd_done = 1'b1;
            next_q.st = CS_RUN;
          end
        end
      end
      default: next_q.st = CS_IDLE;
    endcase
    if (issue) begin
      next_q.tx = {1'b1, word};
      next_q.tx_cnt = `LMS_TX_BITS;
    end
    next_q.ready = (next_q.st == CS_RUN) && (next_q.tx_cnt == 7'd0);
  end

  always_ff @(posedge I_SYS_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  assign link.sclk = q.sclk;
  assign link.serial_data_in  = q.serial_data_in;
  assign O_READY   = q.ready;
  assign O_RD_DATA = q.rd_sh;
  assign O_RD_DONE = q.rd_done;
endmodule

// file: hw/lms_dev.sv
// Driver end: serial command decode, configuration banks and scan timing.
`timescale 1ns/1ns
`include "lms_map.svh"
// Notes on behaviour
// RQ1 - Grayscale clock is serial clock times multiplier plus one.
// RQ2 - Line switch lasts code times forty clocks.
// RQ3 - Segment length field sets clocks per segment.
// RQ4 - Blank adjust adds clocks to each sub-period.
// RQ5 - Large blank count moves whole share into segments.
// RQ6 - Controller spends share on segment or switch.
// RQ7 - Controller spreads leftover blank over sub-periods.
// RQ8 - Every scan line driven once per sub-period.
// RQ9 - Full scale equals segment length times sub-periods.
// RQ10 - Frame: lines times sub-periods, then blank.
// RQ11 - Controller: chain index, configuration, then frame syncs.
// RQ12 - Chain index command assigns this device's address.
// RQ13 - Frame sync shows last frame, keeps loading.
// RQ14 - Frame sync restarts display timing on all devices.
// RQ15 - Registers readable at any time in frame.
// RQ16 - First two configs wait for sync; others immediate.
// RQ17 - Controller writes configuration in broadcast form.
// RQ18 - Controller writes grayscale data device-addressed.
// RQ19 - Controller sets first four configs before display.
// RQ20 - Controller sends zero data to unused channels.
// RQ21 - Read commands return open and short flags.
// RQ22 - Controller keeps serial clock running continuously.
// RQ23 - Commands enter on data in, reads leave out.
// RQ24 - Leftover blank idles at frame end, outputs off.
module lms_dev
  import lms_pkg::*;
(
  input  wire logic        I_SYS_CLK,
  input  wire logic        I_SYS_RST,
  lms_link_if.dev          link,
  input  wire logic [47:0] I_LED_OPEN,
  input  wire logic [47:0] I_LED_SHORT,
  output logic [4:0]       O_LINE_SEL,
  output logic             O_LINE_ON,
  output logic             O_PWM,
  output logic             O_GRAYSCALE_CLOCK_TICK,
  output logic [7:0]       O_CHIP_ADDR
);
  lms_dev_type q;
  lms_dev_type next_q;
  logic        rise;
  logic        fall;
  logic        done;
  logic [63:0] cmd_word;
  logic [3:0]  cmd;
  logic [3:0]  idx;
  logic [7:0]  dst;
  logic [47:0] data;
  logic        hit;
  logic [47:0] rd_val;
  logic [19:0] interval;
  logic [9:0]  seg_len;
  logic [9:0]  lsw_len;
  logic [9:0]  adj_len;
  logic [4:0]  last_line;
  logic [5:0]  last_sub;
  logic [16:0] level;
  logic [15:0] gs_val;
  logic        seg_end;

  always_comb begin
    next_q = q;
    next_q.sclk_d = link.sclk;
    rise = link.sclk & ~q.sclk_d;
    fall = ~link.sclk & q.sclk_d;
    done = 1'b0;
    cmd_word = {q.rx[62:0], link.serial_data_in};
    cmd  = cmd_word[`LMS_CMD_HI:`LMS_CMD_LO];
    idx  = cmd_word[`LMS_IDX_HI:`LMS_IDX_LO];
    dst  = cmd_word[`LMS_DST_HI:`LMS_DST_LO];
    data = cmd_word[47:0];
    hit  = (dst == `LMS_BROADCAST) || (dst == q.addr); // RQ12
    rd_val = `LMS_CFG_RESET;
    seg_len   = q.cfg_a1[`LMS_SEG_HI:`LMS_SEG_LO]; // RQ3
    lsw_len   = lms_lsw_clocks(q.cfg_a1[`LMS_LSW_HI:`LMS_LSW_LO]); // RQ2
    adj_len   = {4'h0, q.cfg_a1[`LMS_ADJ_HI:`LMS_ADJ_LO]}; // RQ4
    last_line = q.cfg_a0[`LMS_NLINE_HI:`LMS_NLINE_LO];
    last_sub  = q.cfg_a0[`LMS_NSUB_HI:`LMS_NSUB_LO];
    // Grayscale ticks are spread evenly over the measured serial period.
    interval = lms_div({12'h000, q.per},
                       {16'h0000, q.cfg_a0[`LMS_MUL_HI:`LMS_MUL_LO]}
                       + 20'h00001); // RQ1
    gs_val = q.gs[q.bank][q.line[3:0]];
    level  = 17'(q.sub * seg_len) + {7'h00, q.gcnt}; // RQ9
    seg_end = ({1'b0, q.gcnt} + 11'd1) >= {1'b0, seg_len};

    // Serial period measurement and grayscale tick generation.
    next_q.gtick = 1'b0;
    next_q.per_cnt = q.per_cnt + 8'd1;
    next_q.ph = q.ph + 8'd1;
    if (rise) begin
      next_q.per = q.per_cnt + 8'd1;
      next_q.per_cnt = 8'd0;
    end
    // No ticks before the first frame sync, because the period measured
    // just after reset is not yet a whole serial period.
    if ({12'h000, q.ph} + 20'h00001 >= interval) begin
      next_q.ph = 8'd0;
      next_q.gtick = (q.st != DS_IDLE); // RQ1
    end

    // Command receiver: a start bit, then a 64-bit word, sampled on rise.
    if (rise) begin
      if (!q.rx_busy) begin
        next_q.rx_busy = link.serial_data_in; // RQ23
        next_q.rx_cnt = 7'd0;
      end else begin
        next_q.rx = cmd_word;
        next_q.rx_cnt = q.rx_cnt + 7'd1;
        if (q.rx_cnt == `LMS_WORD_BITS - 7'd1) begin
          next_q.rx_busy = 1'b0;
          done = 1'b1;
        end
      end
    end

    // Read data leaves on data out, one bit per falling edge.
    if (fall && q.tx_cnt != 6'd0) begin
      next_q.serial_data_out = q.tx[48]; // RQ23
      next_q.tx = {q.tx[47:0], 1'b0};
      next_q.tx_cnt = q.tx_cnt - 6'd1;
    end else if (fall) begin
      next_q.serial_data_out = 1'b0;
    end

    // Display timing advances one step per grayscale tick.
    if (q.gtick) begin
      next_q.gcnt = q.gcnt + 10'd1;
      case (q.st)
        DS_SEG: begin
          next_q.pwm = (level + 17'd1) < {1'b0, gs_val};
          if (seg_end) begin
            next_q.st = DS_SWITCH; // RQ10
            next_q.gcnt = 10'd0;
            next_q.pwm = 1'b0;
            next_q.line_on = 1'b0;
          end
        end
        DS_SWITCH: begin
          if (q.gcnt + 10'd1 >= lsw_len) begin // RQ2
            next_q.gcnt = 10'd0;
            if (q.line != last_line) begin
              next_q.line = q.line + 5'd1; // RQ8
              next_q.st = DS_SEG;
            end else begin
              next_q.st = DS_SUBBLANK; // RQ4
            end
          end
        end
        DS_SUBBLANK: begin
          if (q.gcnt >= adj_len) begin // RQ4
            next_q.gcnt = 10'd0;
            next_q.line = 5'd0;
            if (q.sub != last_sub) begin
              next_q.sub = q.sub + 6'd1; // RQ8
              next_q.st = DS_SEG;
            end else begin
              next_q.st = DS_FBLANK; // RQ24
            end
          end
        end
        DS_FBLANK: begin
          next_q.gcnt = 10'd0;
          next_q.pwm = 1'b0; // RQ24
        end
        DS_IDLE: next_q.gcnt = 10'd0;
        default: next_q.st = DS_IDLE;
      endcase
      if (next_q.st == DS_SEG && q.st != DS_SEG) begin
        next_q.line_on = 1'b1;
        next_q.pwm = {1'b0, q.gs[q.bank][next_q.line[3:0]]} >
                     17'(next_q.sub * seg_len);
      end
    end

    if (done) begin
      case (cmd)
        `LMS_CMD_CHAIN: next_q.addr = data[7:0]; // RQ12
        `LMS_CMD_CFG_WR: begin
          if (hit) begin
            case (idx)
              `LMS_IDX_CFG0: next_q.cfg_sh0 = data; // RQ16
              `LMS_IDX_CFG1: next_q.cfg_sh1 = data; // RQ16
              `LMS_IDX_CFG2: next_q.cfg2 = data; // RQ16
              `LMS_IDX_CFG3: next_q.cfg3 = data; // RQ16
              default: next_q.cfg3 = q.cfg3;
            endcase
          end
        end
        `LMS_CMD_GS_WR: begin
          if (dst == q.addr) begin
            next_q.gs[~q.bank][data[`LMS_GS_LINE_HI:`LMS_GS_LINE_LO]] =
              data[15:0]; // RQ13
          end
        end
        `LMS_CMD_VSYNC: begin
          next_q.cfg_a0 = q.cfg_sh0; // RQ16
          next_q.cfg_a1 = q.cfg_sh1; // RQ16
          next_q.bank = ~q.bank; // RQ13
          next_q.st = DS_SEG; // RQ14
          next_q.line = 5'd0;
          next_q.sub = 6'd0;
          next_q.gcnt = 10'd0;
          next_q.line_on = 1'b1;
          next_q.pwm = 1'b0;
          // The tick phase restarts so the first segment gets whole ticks.
          next_q.ph = 8'(interval - 20'h00001); // RQ14
          next_q.gtick = 1'b0;
        end
        `LMS_CMD_READ: begin
          if (hit) begin
            case (idx)
              `LMS_IDX_CFG0: rd_val = q.cfg_sh0;
              `LMS_IDX_CFG1: rd_val = q.cfg_sh1;
              `LMS_IDX_CFG2: rd_val = q.cfg2;
              `LMS_IDX_CFG3: rd_val = q.cfg3;
              `LMS_IDX_OPEN: rd_val = I_LED_OPEN; // RQ21
              `LMS_IDX_SHORT: rd_val = I_LED_SHORT; // RQ21
              default: rd_val = `LMS_CFG_RESET;
            endcase
            next_q.tx = {1'b1, rd_val}; // RQ15
            next_q.tx_cnt = 6'd49;
          end
        end
        default: next_q.rx_cnt = 7'd0;
      endcase
    end
  end

  always_ff @(posedge I_SYS_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  assign link.serial_data_out   = q.serial_data_out;
  assign O_LINE_SEL  = q.line;
  assign O_LINE_ON   = q.line_on;
  assign O_PWM       = q.pwm;
  assign O_GRAYSCALE_CLOCK_TICK = q.gtick;
  assign O_CHIP_ADDR = q.addr;
endmodule

// file: hw/lms_link_if.sv
// Three-wire serial link between the display controller and the driver.
`timescale 1ns/1ns
interface lms_link_if;
  logic sclk;
  logic serial_data_in;
  logic serial_data_out;
  modport dev (input sclk, input serial_data_in, output serial_data_out);
  modport ctl (output sclk, output serial_data_in, input serial_data_out);
endinterface

// file: hw/lms_map.svh
// Offsets, field positions, command codes and timing counts of the scan link.
`ifndef LMS_MAP_SVH
`define LMS_MAP_SVH
`define LMS_WORD_BITS     7'd64
`define LMS_TX_BITS       7'd65
`define LMS_RD_BITS       6'd48
`define LMS_CMD_HI        63
`define LMS_CMD_LO        60
`define LMS_IDX_HI        59
`define LMS_IDX_LO        56
`define LMS_DST_HI        55
`define LMS_DST_LO        48
`define LMS_CMD_CHAIN     4'h1
`define LMS_CMD_CFG_WR    4'h2
`define LMS_CMD_GS_WR     4'h3
`define LMS_CMD_VSYNC     4'h4
`define LMS_CMD_READ      4'h5
`define LMS_BROADCAST     8'hFF
`define LMS_IDX_CFG0      4'h0
`define LMS_IDX_CFG1      4'h1
`define LMS_IDX_CFG2      4'h2
`define LMS_IDX_CFG3      4'h3
`define LMS_IDX_OPEN      4'hE
`define LMS_IDX_SHORT     4'hF
`define LMS_MUL_HI        3
`define LMS_MUL_LO        0
`define LMS_NLINE_HI      8
`define LMS_NLINE_LO      4
`define LMS_NSUB_HI       14
`define LMS_NSUB_LO       9
`define LMS_SEG_HI        9
`define LMS_SEG_LO        0
`define LMS_LSW_HI        40
`define LMS_LSW_LO        37
`define LMS_ADJ_HI        46
`define LMS_ADJ_LO        41
`define LMS_GS_LINE_HI    19
`define LMS_GS_LINE_LO    16
`define LMS_LSW_STEP      10'd40
`define LMS_CFG_RESET     48'h0000_0000_0000
`define LMS_ADDR_RESET    8'h00
`endif

// file: hw/lms_pkg.sv
// Types and shared arithmetic of the LED matrix scan link.
`include "lms_map.svh"
package lms_pkg;
  typedef enum logic [2:0] {
    DS_IDLE, DS_SEG, DS_SWITCH, DS_SUBBLANK, DS_FBLANK
  } lms_dev_state_type;

  typedef enum logic [2:0] {
    CS_IDLE, CS_BOOT, CS_RUN, CS_RDWAIT, CS_RDGET
  } lms_ctl_state_type;

  typedef struct packed {
    logic                   sclk_d;
    logic [63:0]            rx;
    logic [6:0]             rx_cnt;
    logic                   rx_busy;
    logic [7:0]             addr;
    logic [47:0]            cfg_sh0;
    logic [47:0]            cfg_sh1;
    logic [47:0]            cfg_a0;
    logic [47:0]            cfg_a1;
    logic [47:0]            cfg2;
    logic [47:0]            cfg3;
    logic [1:0][15:0][15:0] gs;
    logic                   bank;
    logic [48:0]            tx;
    logic [5:0]             tx_cnt;
    logic                   serial_data_out;
    logic [7:0]             per_cnt;
    logic [7:0]             per;
    logic [7:0]             ph;
    logic                   gtick;
    lms_dev_state_type      st;
    logic [9:0]             gcnt;
    logic [4:0]             line;
    logic [5:0]             sub;
    logic                   pwm;
    logic                   line_on;
  } lms_dev_type;

  typedef struct packed {
    logic              sclk;
    logic              div;
    logic              serial_data_in;
    logic [64:0]       tx;
    logic [6:0]        tx_cnt;
    lms_ctl_state_type st;
    logic [2:0]        step;
    logic [47:0]       rd_sh;
    logic [5:0]        rd_cnt;
    logic              ready;
    logic              rd_done;
  } lms_ctl_type;

  function automatic logic [19:0] lms_div(input logic [19:0] a,
                                          input logic [19:0] b);
    lms_div = (b == 20'h00000) ? 20'h00000 : a / b;
  endfunction

  function automatic logic [9:0] lms_lsw_clocks(input logic [3:0] code);
    lms_lsw_clocks = 10'({6'h00, code} * `LMS_LSW_STEP);
  endfunction
endpackage
